// ===== hw/pah_top.sv
// protective alarm handler with axi4-lite register slave
`timescale 1ns/100ps
`default_nettype none
module pah_top
	import pah_pkg::*;
#(
	parameter int LED_ON_CYC = PAH_LED_ON_CYC,
	parameter int LED_OFF_CYC = PAH_LED_OFF_CYC,
	parameter int LED_GAP_CYC = PAH_LED_GAP_CYC
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [PAH_NFAULT-1:0] fault_pulse,
	input wire logic overheat_level,
	input wire logic overload_active,
	input wire logic deviation_level,
	input wire logic alarm_clear_pin,
	input wire logic panic_stop_input,
	output logic alarm_query_or_output,
	output logic alarm_led,
	output logic halt_motion,
	output logic motor_deenergise,
	output logic irq
);
	// alarm state
	logic [7:0] code_r, code_nxt;
	logic [2:0] blinks_r;
	logic [1:0] clrcls_r; // 0 clear cmd, 1 if corrected, 2 reset only, 3 never
	logic halt_r, deen_r;
	logic [3:0] cfg_r;
	logic [31:0] ovld_lim_r, ovld_acc_r;
	logic [1:0] irq_st_r, irq_mask_r;
	// pin synchronisers
	logic [2:0] clr_sync_r, panic_stop_input_sync_r;
	logic clr_state_r, panic_stop_input_state_r;
	// bus
	logic aw_got_r, w_got_r;
	logic [7:0] aw_addr_r;
	logic [31:0] w_data_r;
	logic [3:0] w_strb_r;
	logic bvalid_r, rvalid_r;
	logic [1:0] bresp_r, rresp_r;
	logic [31:0] rdata_r;

	wire logic wr_fire = aw_got_r && w_got_r && !bvalid_r;
	wire logic wr_ctrl = wr_fire && aw_addr_r == PAH_OFS_CTRL && w_strb_r[0];
	wire logic wr_cfg = wr_fire && aw_addr_r == PAH_OFS_CFG && w_strb_r[0];
	wire logic wr_ovld = wr_fire && aw_addr_r == PAH_OFS_OVLD;
	wire logic wr_ist = wr_fire && aw_addr_r == PAH_OFS_IRQ_ST && w_strb_r[0];
	wire logic wr_imask = wr_fire && aw_addr_r == PAH_OFS_IRQ_MASK && w_strb_r[0];
	// code and status are read-only, so a write there answers with an error
	wire logic wr_known = aw_addr_r == PAH_OFS_CTRL ||
		aw_addr_r == PAH_OFS_CFG ||
		aw_addr_r == PAH_OFS_OVLD ||
		aw_addr_r == PAH_OFS_IRQ_ST ||
		aw_addr_r == PAH_OFS_IRQ_MASK;

	wire logic cmd_clear = wr_ctrl && w_data_r[PAH_CTRL_CLEAR];
	wire logic cmd_reset = wr_ctrl && w_data_r[PAH_CTRL_RESET];
	wire logic cmd_user = wr_ctrl && w_data_r[PAH_CTRL_USERSET];
	wire logic cmd_panic = wr_ctrl && w_data_r[PAH_CTRL_PANIC];

	// change counts once second and third stages agree
	// a pin pulse shorter than two clocks may be missed; the pins are slow switches
	wire logic clr_agree = clr_sync_r[1] == clr_sync_r[2];
	wire logic panic_stop_input_agree = panic_stop_input_sync_r[1] == panic_stop_input_sync_r[2];
	wire logic clr_fall = clr_agree && clr_state_r && !clr_sync_r[2];
	wire logic panic_stop_input_rise = panic_stop_input_agree && !panic_stop_input_state_r && panic_stop_input_sync_r[2];

	wire logic ovld_trip = ovld_acc_r >= ovld_lim_r && overload_active;

	// fault vector with internal and command sources merged in
	logic [PAH_NFAULT-1:0] fault_v;
	always_comb begin
		fault_v = fault_pulse;
		fault_v[PAH_F_USER] = fault_pulse[PAH_F_USER] | cmd_user;
		fault_v[PAH_F_PANIC] = fault_pulse[PAH_F_PANIC] | cmd_panic | panic_stop_input_rise;
		fault_v[PAH_F_OVHEAT] = fault_pulse[PAH_F_OVHEAT] | overheat_level;
		fault_v[PAH_F_OVLOAD] = fault_pulse[PAH_F_OVLOAD] | ovld_trip;
		fault_v[PAH_F_DEVIAT] = (fault_pulse[PAH_F_DEVIAT] | deviation_level) &
			cfg_r[PAH_CFG_DEVACT];
	end

	// lowest index wins when several faults arrive together
	logic [7:0] f_code;
	logic [2:0] f_blinks;
	logic [1:0] f_cls;
	logic f_halt, f_deen;
	logic f_any;
	always_comb begin
		f_code = PAH_CODE_NONE;
		f_blinks = 3'h0;
		f_cls = 2'd0;
		f_halt = 1'b0;
		f_deen = 1'b0;
		f_any = 1'b0;
		for (int i = PAH_NFAULT - 1; i >= 0; i--) begin
			if (fault_v[i]) begin
				f_any = 1'b1;
				f_halt = 1'b1;
				f_deen = 1'b0;
				f_cls = 2'd0;
				f_blinks = PAH_BLINK_SEQ;
				unique case (i)
					PAH_F_STACK: f_code = PAH_CODE_STACK;
					PAH_F_SEQREF: f_code = PAH_CODE_SEQREF;
					PAH_F_CALCOVF: f_code = PAH_CODE_CALCOVF;
					PAH_F_PRANGE: f_code = PAH_CODE_PRANGE;
					PAH_F_ZDIV: f_code = PAH_CODE_ZDIV;
					PAH_F_PCWR: f_code = PAH_CODE_PCWR;
					PAH_F_UVAR: f_code = PAH_CODE_UVAR;
					PAH_F_PWRITE: f_code = PAH_CODE_PWRITE;
					PAH_F_MOTION: f_code = PAH_CODE_MOTION;
					PAH_F_USER: f_code = PAH_CODE_USER;
					PAH_F_OVHEAT: begin
						f_code = PAH_CODE_OVHEAT;
						f_blinks = PAH_BLINK_DRV;
						f_deen = 1'b1;
						f_cls = 2'd1;
					end
					PAH_F_OVLOAD: begin
						f_code = PAH_CODE_OVLOAD;
						f_blinks = PAH_BLINK_DRV;
						f_deen = 1'b1;
					end
					PAH_F_OVVOLT: begin
						f_code = PAH_CODE_OVVOLT;
						f_blinks = PAH_BLINK_VOLT;
						f_deen = 1'b1;
						f_cls = 2'd2;
					end
					PAH_F_DEVIAT: begin
						f_code = PAH_CODE_DEVIAT;
						f_blinks = PAH_BLINK_DEV;
						f_cls = 2'd1;
					end
					PAH_F_PANIC: begin
						f_code = PAH_CODE_PANIC;
						f_blinks = PAH_BLINK_PANIC;
						f_deen = cfg_r[PAH_CFG_ALARM_ACTION_SETTING];
					end
					default: begin
						f_code = PAH_CODE_SYSERR;
						f_blinks = PAH_BLINK_SYS;
						f_deen = 1'b1;
						f_cls = 2'd3;
					end
				endcase
			end
		end
	end

	wire logic cond_gone = !(code_r == PAH_CODE_OVHEAT && overheat_level) &&
		!(code_r == PAH_CODE_DEVIAT && deviation_level);
	wire logic clear_ok = clrcls_r == 2'd0 || (clrcls_r == 2'd1 && cond_gone);
	wire logic idle = code_r == PAH_CODE_NONE;
	// clear requests that the latched class allows
	wire logic clr_req_ok = (cmd_clear || clr_fall) && clear_ok;
	wire logic rst_req_ok = cmd_reset && clrcls_r != 2'd3;
	wire logic do_clear = !idle && (clr_req_ok || rst_req_ok);
	wire logic latch_new = f_any && (idle || do_clear);

	// a fresh fault in the clearing cycle wins over the clear
	always_comb begin
		code_nxt = code_r;
		if (latch_new)
			code_nxt = f_code;
		else if (do_clear)
			code_nxt = PAH_CODE_NONE;
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			code_r <= PAH_CODE_NONE;
			blinks_r <= 3'h0;
			clrcls_r <= 2'd0;
			halt_r <= 1'b0;
			deen_r <= 1'b0;
		end else if (clk_en) begin
			code_r <= code_nxt;
			if (latch_new) begin
				blinks_r <= f_blinks;
				clrcls_r <= f_cls;
				halt_r <= f_halt;
				deen_r <= f_deen;
			end else if (do_clear) begin
				blinks_r <= 3'h0;
				clrcls_r <= 2'd0;
				halt_r <= 1'b0;
				deen_r <= 1'b0;
			end
		end
	end

	// overload accumulator: time spent above maximum torque
	// it saturates instead of wrapping, so a long overload cannot read as short
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			ovld_acc_r <= 32'h0000_0000;
		end else if (clk_en) begin
			if (do_clear && code_r == PAH_CODE_OVLOAD)
				ovld_acc_r <= 32'h0000_0000;
			else if (overload_active && ovld_acc_r != 32'hFFFF_FFFF)
				ovld_acc_r <= ovld_acc_r + 32'h0000_0001;
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			clr_sync_r <= 3'b000;
			panic_stop_input_sync_r <= 3'b000;
			clr_state_r <= 1'b0;
			panic_stop_input_state_r <= 1'b0;
		end else if (clk_en) begin
			clr_sync_r <= {clr_sync_r[1:0], alarm_clear_pin};
			panic_stop_input_sync_r <= {panic_stop_input_sync_r[1:0], panic_stop_input};
			if (clr_agree)
				clr_state_r <= clr_sync_r[2];
			if (panic_stop_input_agree)
				panic_stop_input_state_r <= panic_stop_input_sync_r[2];
		end
	end

	// led blink engine: n pulses then a long gap, repeating
	// the gap ends through one idle cycle, so dark time is one cycle longer than the gap
	typedef enum logic [1:0] {PAH_LED_IDLE, PAH_LED_ON, PAH_LED_OFF, PAH_LED_GAP} pah_led_e;
	pah_led_e led_st_r;
	logic [31:0] led_cnt_r;
	logic [2:0] led_num_r;
	wire logic led_done = led_cnt_r == 32'h0000_0000;
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			led_st_r <= PAH_LED_IDLE;
			led_cnt_r <= 32'h0000_0000;
			led_num_r <= 3'h0;
		end else if (clk_en) begin
			if (idle) begin
				led_st_r <= PAH_LED_IDLE;
			end else begin
				unique case (led_st_r)
					PAH_LED_IDLE: begin
						led_st_r <= PAH_LED_ON;
						led_cnt_r <= 32'(LED_ON_CYC - 1);
						led_num_r <= blinks_r;
					end
					PAH_LED_ON: if (led_done) begin
						led_st_r <= (led_num_r <= 3'h1) ? PAH_LED_GAP : PAH_LED_OFF;
						led_cnt_r <= (led_num_r <= 3'h1) ? 32'(LED_GAP_CYC - 1) :
							32'(LED_OFF_CYC - 1);
						led_num_r <= led_num_r - 3'h1;
					end else led_cnt_r <= led_cnt_r - 32'h0000_0001;
					PAH_LED_OFF: if (led_done) begin
						led_st_r <= PAH_LED_ON;
						led_cnt_r <= 32'(LED_ON_CYC - 1);
					end else led_cnt_r <= led_cnt_r - 32'h0000_0001;
					PAH_LED_GAP: if (led_done) begin
						led_st_r <= PAH_LED_IDLE;
					end else led_cnt_r <= led_cnt_r - 32'h0000_0001;
				endcase
			end
		end
	end

	// registers and interrupt flags
	// status bit 0 marks a new latch, bit 1 a successful clear
	wire logic [1:0] irq_ev = {do_clear, latch_new};
	wire logic [1:0] irq_wclr = wr_ist ? w_data_r[1:0] : 2'b00;
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			cfg_r <= PAH_CFG_RESET;
			ovld_lim_r <= PAH_OVLD_RESET;
			irq_st_r <= 2'b00;
			irq_mask_r <= 2'b00;
		end else if (clk_en) begin
			if (wr_cfg)
				cfg_r <= w_data_r[3:0];
			if (wr_ovld)
				ovld_lim_r <= w_data_r;
			if (wr_imask)
				irq_mask_r <= w_data_r[1:0];
			// set wins over write-one-to-clear
			irq_st_r <= (irq_st_r & ~irq_wclr) | irq_ev;
		end
	end

	// axi4-lite slave, one write and one read at a time
	// ready drops while an answer waits, so a stalled master never loses a beat
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
			aw_addr_r <= 8'h00;
			w_data_r <= 32'h0000_0000;
			w_strb_r <= 4'h0;
			bvalid_r <= 1'b0;
			bresp_r <= PAH_RESP_OKAY;
			rvalid_r <= 1'b0;
			rresp_r <= PAH_RESP_OKAY;
			rdata_r <= 32'h0000_0000;
		end else if (clk_en) begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got_r <= 1'b1;
				aw_addr_r <= {s_axi_awaddr[7:2], 2'b00};
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got_r <= 1'b1;
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_got_r <= 1'b0;
				w_got_r <= 1'b0;
				bvalid_r <= 1'b1;
				bresp_r <= wr_known ? PAH_RESP_OKAY : PAH_RESP_SLVERR;
			end else if (s_axi_bready)
				bvalid_r <= 1'b0;
			if (s_axi_arvalid && s_axi_arready) begin
				rvalid_r <= 1'b1;
				rresp_r <= PAH_RESP_OKAY;
				unique case ({s_axi_araddr[7:2], 2'b00})
					PAH_OFS_CTRL: rdata_r <= 32'h0000_0000;
					PAH_OFS_CODE: rdata_r <= {24'h00_0000, code_r};
					PAH_OFS_CFG: rdata_r <= {28'h000_0000, cfg_r};
					PAH_OFS_OVLD: rdata_r <= ovld_lim_r;
					PAH_OFS_IRQ_ST: rdata_r <= {30'h0000_0000, irq_st_r};
					PAH_OFS_IRQ_MASK: rdata_r <= {30'h0000_0000, irq_mask_r};
					PAH_OFS_STATUS: rdata_r <= {24'h00_0000, deen_r, halt_r,
						clrcls_r, 1'b0, blinks_r};
					default: begin
						rdata_r <= 32'h0000_0000;
						rresp_r <= PAH_RESP_SLVERR;
					end
				endcase
			end else if (s_axi_rready)
				rvalid_r <= 1'b0;
		end
	end

	assign s_axi_awready = clk_en && !aw_got_r && !bvalid_r;
	assign s_axi_wready = clk_en && !w_got_r && !bvalid_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_arready = clk_en && !rvalid_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rresp = rresp_r;
	assign s_axi_rdata = rdata_r;
	assign alarm_led = led_st_r == PAH_LED_ON;
	assign alarm_query_or_output = cfg_r[PAH_CFG_OUT_EN] &&
		((!idle) ^ cfg_r[PAH_CFG_OUT_POL]);
	assign halt_motion = halt_r;
	assign motor_deenergise = deen_r;
	assign irq = |(irq_st_r & irq_mask_r);
endmodule
`default_nettype wire

// ===== hw/pah_pkg.sv
// constants, codes and register map of the protective alarm handler
// Behaviour
// - fault blinks led and drives alarm output
// - alarm query returns active alarm code
// - blinks per cycle identify alarm category
// - clear command clears only clearable codes
// - reset command clears the alarm state
// - clear input acts on its falling edge
// - serious alarms never clear; some need reset
// - no fault: code zero, led dark
// - stack, call, overflow: one blink, halt, clearable
// - range, divide, counter write: one blink, clearable
// - variable, param write, motion conflict: one blink
// - user alarm set latches user code
// - overheat: two blinks, de-energise, clear once cool
// - overload time exceeded: two blinks, de-energise
// - overvoltage: three blinks, clear has no effect
// - deviation alarm: four blinks, clear once corrected
// - panic stop: six blinks, alarm action applies
package pah_pkg;
	localparam logic [7:0] PAH_CODE_NONE = 8'h00;
	localparam logic [7:0] PAH_CODE_STACK = 8'h90;
	localparam logic [7:0] PAH_CODE_SEQREF = 8'h94;
	localparam logic [7:0] PAH_CODE_CALCOVF = 8'h98;
	localparam logic [7:0] PAH_CODE_PRANGE = 8'h99;
	localparam logic [7:0] PAH_CODE_ZDIV = 8'h9A;
	localparam logic [7:0] PAH_CODE_PCWR = 8'h9D;
	localparam logic [7:0] PAH_CODE_UVAR = 8'h9E;
	localparam logic [7:0] PAH_CODE_PWRITE = 8'h9F;
	localparam logic [7:0] PAH_CODE_MOTION = 8'hA0;
	localparam logic [7:0] PAH_CODE_USER = 8'hE0;
	localparam logic [7:0] PAH_CODE_OVHEAT = 8'h21;
	localparam logic [7:0] PAH_CODE_OVLOAD = 8'h30;
	localparam logic [7:0] PAH_CODE_OVVOLT = 8'h22;
	localparam logic [7:0] PAH_CODE_DEVIAT = 8'h10;
	localparam logic [7:0] PAH_CODE_PANIC = 8'h68;
	localparam logic [7:0] PAH_CODE_SYSERR = 8'hF0;
	localparam logic [2:0] PAH_BLINK_SEQ = 3'h1;
	localparam logic [2:0] PAH_BLINK_DRV = 3'h2;
	localparam logic [2:0] PAH_BLINK_VOLT = 3'h3;
	localparam logic [2:0] PAH_BLINK_DEV = 3'h4;
	localparam logic [2:0] PAH_BLINK_PANIC = 3'h6;
	localparam logic [2:0] PAH_BLINK_SYS = 3'h7;
	// fault source bit positions in the fault vector
	localparam int PAH_NFAULT = 16;
	localparam int PAH_F_STACK = 0;
	localparam int PAH_F_SEQREF = 1;
	localparam int PAH_F_CALCOVF = 2;
	localparam int PAH_F_PRANGE = 3;
	localparam int PAH_F_ZDIV = 4;
	localparam int PAH_F_PCWR = 5;
	localparam int PAH_F_UVAR = 6;
	localparam int PAH_F_PWRITE = 7;
	localparam int PAH_F_MOTION = 8;
	localparam int PAH_F_USER = 9;
	localparam int PAH_F_OVHEAT = 10;
	localparam int PAH_F_OVLOAD = 11;
	localparam int PAH_F_OVVOLT = 12;
	localparam int PAH_F_DEVIAT = 13;
	localparam int PAH_F_PANIC = 14;
	localparam int PAH_F_SYSERR = 15;
	// register byte offsets
	localparam logic [7:0] PAH_OFS_CTRL = 8'h00;
	localparam logic [7:0] PAH_OFS_CODE = 8'h04;
	localparam logic [7:0] PAH_OFS_CFG = 8'h08;
	localparam logic [7:0] PAH_OFS_OVLD = 8'h0C;
	localparam logic [7:0] PAH_OFS_IRQ_ST = 8'h10;
	localparam logic [7:0] PAH_OFS_IRQ_MASK = 8'h14;
	localparam logic [7:0] PAH_OFS_STATUS = 8'h18;
	// ctrl bits (write one to act)
	localparam int PAH_CTRL_CLEAR = 0;
	localparam int PAH_CTRL_RESET = 1;
	localparam int PAH_CTRL_USERSET = 2;
	localparam int PAH_CTRL_PANIC = 3;
	// cfg bits
	localparam int PAH_CFG_OUT_EN = 0;
	localparam int PAH_CFG_OUT_POL = 1;
	localparam int PAH_CFG_ALARM_ACTION_SETTING = 2;
	localparam int PAH_CFG_DEVACT = 3;
	localparam logic [31:0] PAH_OVLD_RESET = 32'h0000_1000;
	localparam logic [3:0] PAH_CFG_RESET = 4'h1;
	// irq bits
	localparam int PAH_IRQ_RAISE = 0;
	localparam int PAH_IRQ_CLEAR = 1;
	// led timing
	localparam int PAH_LED_ON_MS = 200;
	localparam int PAH_LED_OFF_MS = 200;
	localparam int PAH_LED_GAP_MS = 1400;
	localparam int PAH_CLK_HZ = 40_000_000;
	localparam int PAH_LED_ON_CYC = PAH_LED_ON_MS * (PAH_CLK_HZ / 1000);
	localparam int PAH_LED_OFF_CYC = PAH_LED_OFF_MS * (PAH_CLK_HZ / 1000);
	localparam int PAH_LED_GAP_CYC = PAH_LED_GAP_MS * (PAH_CLK_HZ / 1000);
	// response codes
	localparam logic [1:0] PAH_RESP_OKAY = 2'b00;
	localparam logic [1:0] PAH_RESP_SLVERR = 2'b10;
endpackage

// ===== tb/pah_monitor.sv
// port-level assertion checker for the protective alarm handler
`timescale 1ns/100ps
`default_nettype none
module pah_monitor
	import pah_pkg::*;
#(
	parameter int LED_ON_CYC = 4
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire logic [PAH_NFAULT-1:0] fault_pulse,
	input wire logic overheat_level,
	input wire logic alarm_clear_pin,
	input wire logic panic_stop_input,
	input wire logic alarm_led,
	input wire logic halt_motion,
	input wire logic motor_deenergise
);
	logic quiet;
	int on_len_r;
	// quiet means the clock is enabled and no stopping alarm is in force
	assign quiet = clk_en && !halt_motion && !motor_deenergise;
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			on_len_r <= 0;
		end else begin
			on_len_r <= alarm_led ? on_len_r + 1 : 0;
		end
	end
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!reset_n);
	sequence s_stops;
		##[1:3] halt_motion;
	endsequence
	sequence s_unpowers;
		##[1:3] motor_deenergise;
	endsequence
	a_seq_fault_stops: assert property (quiet && |fault_pulse[2:0] |-> s_stops)
		else $error("sequence fault did not halt motion");
	a_param_fault_stops: assert property (quiet && |fault_pulse[5:3] |-> s_stops)
		else $error("parameter fault did not halt motion");
	a_var_fault_stops: assert property (quiet && |fault_pulse[8:6] |-> s_stops)
		else $error("access fault did not halt motion");
	a_heat_unpowers: assert property (quiet && overheat_level |-> s_unpowers)
		else $error("overheat did not de-energise");
	a_volt_unpowers: assert property (quiet && fault_pulse[PAH_F_OVVOLT] |-> s_unpowers)
		else $error("overvoltage did not de-energise");
	a_panic_acts: assert property ($rose(panic_stop_input) && quiet |-> ##[2:8] !quiet)
		else $error("panic stop had no effect");
	a_led_starts: assert property ($rose(halt_motion) |-> ##[1:30] alarm_led)
		else $error("alarm led never lit");
	// a pulse cut short by a clear is excused by the quiet test two cycles on
	a_led_pulse_len: assert property ($fell(alarm_led) ##2 !quiet |->
		$past(on_len_r, 2) == LED_ON_CYC)
		else $error("led on phase has wrong length");
	a_pin_rise_holds: assert property ($rose(alarm_clear_pin) && !quiet |-> !quiet[*6])
		else $error("alarm cleared on rising clear input");
endmodule
`default_nettype wire

// ===== tb/pah_host.sv
// host model issuing register commands over axi4-lite
`timescale 1ns/100ps
`default_nettype none
module pah_host (
	input wire logic clk_sys,
	output logic [7:0] s_axi_awaddr,
	output logic s_axi_awvalid,
	input wire logic s_axi_awready,
	output logic [31:0] s_axi_wdata,
	output logic [3:0] s_axi_wstrb,
	output logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	output logic s_axi_bready,
	output logic [7:0] s_axi_araddr,
	output logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	output logic s_axi_rready
);
	initial begin
		s_axi_awaddr = 8'h00;
		s_axi_awvalid = 1'h0;
		s_axi_wdata = 32'h0000_0000;
		s_axi_wstrb = 4'h0;
		s_axi_wvalid = 1'h0;
		s_axi_bready = 1'h0;
		s_axi_araddr = 8'h00;
		s_axi_arvalid = 1'h0;
		s_axi_rready = 1'h0;
	end
	// address and data offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic ap;
		logic wp;
		@(posedge clk_sys);
		ap = 1'h1;
		wp = 1'h1;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hf;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		forever begin
			@(posedge clk_sys);
			if (!ap && !wp && s_axi_bvalid) begin
				r = s_axi_bresp;
				s_axi_bready <= 1'h0;
				break;
			end
			if (ap && s_axi_awready) begin
				ap = 1'h0;
				s_axi_awvalid <= 1'h0;
			end
			if (wp && s_axi_wready) begin
				wp = 1'h0;
				s_axi_wvalid <= 1'h0;
			end
		end
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ap;
		@(posedge clk_sys);
		ap = 1'h1;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		forever begin
			@(posedge clk_sys);
			if (!ap && s_axi_rvalid) begin
				d = s_axi_rdata;
				r = s_axi_rresp;
				s_axi_rready <= 1'h0;
				break;
			end
			if (ap && s_axi_arready) begin
				ap = 1'h0;
				s_axi_arvalid <= 1'h0;
			end
		end
	endtask
endmodule
`default_nettype wire

// ===== tb/tb_protective_alarm_handler.sv
// self-checking testbench for the protective alarm handler
`timescale 1ns/100ps
`default_nettype none
module tb_protective_alarm_handler;
	import pah_pkg::*;
	logic clk_sys = 1'h0;
	logic reset_n = 1'h0;
	logic clk_en = 1'h1;
	logic [PAH_NFAULT-1:0] fault_pulse = '0;
	logic overheat_level = 1'h0;
	logic overload_active = 1'h0;
	logic deviation_level = 1'h0;
	logic alarm_clear_pin = 1'h0;
	logic panic_stop_input = 1'h0;
	logic alarm_query_or_output, alarm_led, halt_motion, motor_deenergise, irq;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	int fail_count = 0;
	int check_count = 0;
	logic [7:0] seq_codes [9] = '{PAH_CODE_STACK, PAH_CODE_SEQREF, PAH_CODE_CALCOVF,
		PAH_CODE_PRANGE, PAH_CODE_ZDIV, PAH_CODE_PCWR, PAH_CODE_UVAR, PAH_CODE_PWRITE,
		PAH_CODE_MOTION};
	always #12.5 clk_sys = ~clk_sys;
	// short led phases keep each blink count within a few dozen cycles
	pah_top #(.LED_ON_CYC(4), .LED_OFF_CYC(4), .LED_GAP_CYC(16)) u_dut (
		.clk_sys, .reset_n, .clk_en, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .fault_pulse,
		.overheat_level, .overload_active, .deviation_level, .alarm_clear_pin,
		.panic_stop_input, .alarm_query_or_output, .alarm_led, .halt_motion,
		.motor_deenergise, .irq
	);
	pah_host u_host (
		.clk_sys, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready
	);
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			fail_count++;
			$display("MISMATCH at %0t got %h expected %h", $time, g, e);
		end
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] r;
		u_host.rd(a, d, r);
		chk(d & m, e);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [1:0] r;
		u_host.wr(a, d, r);
		chk({30'h0, r}, {30'h0, PAH_RESP_OKAY});
	endtask
	task automatic code(input logic [7:0] e);
		rdc(PAH_OFS_CODE, 32'h0000_00ff, {24'h0, e});
	endtask
	task automatic clr();
		wr(PAH_OFS_CTRL, 32'h0000_0001);
	endtask
	task automatic fire(input int b);
		fault_pulse[b] <= 1'h1;
		idle(1);
		fault_pulse[b] <= 1'h0;
		idle(32);
	endtask
	task automatic pin_clear(input logic [7:0] mid);
		alarm_clear_pin <= 1'h1;
		idle(10);
		code(mid);
		alarm_clear_pin <= 1'h0;
		idle(8);
	endtask
	// counts pulses between two long dark gaps, so a mid-cycle start is skipped
	task automatic blinks(input int e);
		int n;
		int d;
		int s;
		logic p;
		n = 0;
		d = 0;
		s = 0;
		p = 1'h0;
		for (int k = 0; k < 600; k++) begin
			@(posedge clk_sys);
			if (alarm_led && !p) begin
				if (d >= 10) begin
					s++;
					if (s == 2) break;
					n = 0;
				end
				n++;
			end
			d = alarm_led ? 0 : d + 1;
			p = alarm_led;
		end
		chk(n, e);
	endtask
	task automatic done(input string t);
		$display("test %s finished", t);
	endtask
	initial begin
		logic [31:0] d;
		logic [1:0] r;
		idle(4);
		reset_n <= 1'h1;
		idle(2);
		code(PAH_CODE_NONE);
		chk(alarm_led, 1'h0);
		chk(alarm_query_or_output, 1'h0);
		rdc(PAH_OFS_CFG, 32'h0000_000f, {28'h0, PAH_CFG_RESET});
		rdc(PAH_OFS_OVLD, 32'hffff_ffff, PAH_OVLD_RESET);
		u_host.rd(8'h1c, d, r);
		chk({d[31:2], r}, {30'h0, PAH_RESP_SLVERR});
		done("reset");
		for (int i = 0; i < 9; i++) begin
			fire(i);
			code(seq_codes[i]);
			rdc(PAH_OFS_STATUS, 32'h0000_0007, 32'h0000_0001);
			chk(halt_motion, 1'h1);
			chk(alarm_query_or_output, 1'h1);
			blinks(1);
			fire((i + 1) % 9);
			code(seq_codes[i]);
			clr();
			code(PAH_CODE_NONE);
		end
		done("one blink");
		wr(PAH_OFS_CTRL, 32'h0000_0004);
		idle(32);
		code(PAH_CODE_USER);
		clr();
		code(PAH_CODE_NONE);
		overheat_level <= 1'h1;
		idle(32);
		code(PAH_CODE_OVHEAT);
		chk(motor_deenergise, 1'h1);
		blinks(2);
		clr();
		code(PAH_CODE_OVHEAT);
		overheat_level <= 1'h0;
		clr();
		code(PAH_CODE_NONE);
		wr(PAH_OFS_OVLD, 32'h0000_0014);
		overload_active <= 1'h1;
		idle(10);
		code(PAH_CODE_NONE);
		idle(20);
		overload_active <= 1'h0;
		idle(32);
		code(PAH_CODE_OVLOAD);
		chk(motor_deenergise, 1'h1);
		clr();
		code(PAH_CODE_NONE);
		done("drive");
		fire(PAH_F_OVVOLT);
		code(PAH_CODE_OVVOLT);
		blinks(3);
		clr();
		code(PAH_CODE_OVVOLT);
		pin_clear(PAH_CODE_OVVOLT);
		code(PAH_CODE_OVVOLT);
		wr(PAH_OFS_CTRL, 32'h0000_0002);
		code(PAH_CODE_NONE);
		wr(PAH_OFS_CFG, 32'h0000_0009);
		deviation_level <= 1'h1;
		idle(32);
		code(PAH_CODE_DEVIAT);
		blinks(4);
		clr();
		code(PAH_CODE_DEVIAT);
		deviation_level <= 1'h0;
		clr();
		code(PAH_CODE_NONE);
		done("voltage and deviation");
		panic_stop_input <= 1'h1;
		idle(2);
		panic_stop_input <= 1'h0;
		idle(32);
		code(PAH_CODE_PANIC);
		chk(motor_deenergise, 1'h0);
		blinks(6);
		pin_clear(PAH_CODE_PANIC);
		code(PAH_CODE_NONE);
		wr(PAH_OFS_CFG, 32'h0000_000f);
		wr(PAH_OFS_CTRL, 32'h0000_0008);
		idle(32);
		code(PAH_CODE_PANIC);
		chk(motor_deenergise, 1'h1);
		chk(alarm_query_or_output, 1'h0);
		clr();
		code(PAH_CODE_NONE);
		chk(alarm_query_or_output, 1'h1);
		fire(PAH_F_SYSERR);
		clr();
		wr(PAH_OFS_CTRL, 32'h0000_0002);
		code(PAH_CODE_SYSERR);
		reset_n <= 1'h0;
		idle(4);
		reset_n <= 1'h1;
		idle(2);
		code(PAH_CODE_NONE);
		clk_en <= 1'h0;
		fire(PAH_F_STACK);
		clk_en <= 1'h1;
		code(PAH_CODE_NONE);
		done("panic and system");
		wr(PAH_OFS_IRQ_MASK, 32'h0000_0003);
		wr(PAH_OFS_IRQ_ST, 32'h0000_0003);
		fire(PAH_F_ZDIV);
		rdc(PAH_OFS_IRQ_ST, 32'h0000_0003, 32'h0000_0001);
		chk(irq, 1'h1);
		wr(PAH_OFS_IRQ_MASK, 32'h0000_0000);
		chk(irq, 1'h0);
		clr();
		rdc(PAH_OFS_IRQ_ST, 32'h0000_0003, 32'h0000_0003);
		wr(PAH_OFS_IRQ_MASK, 32'h0000_0003);
		chk(irq, 1'h1);
		wr(PAH_OFS_IRQ_ST, 32'h0000_0003);
		chk(irq, 1'h0);
		done("interrupt");
		tally_and_finish();
	end
	initial begin
		repeat (60000) @(posedge clk_sys);
		fail_count++;
		$display("watchdog expired at %0t", $time);
		tally_and_finish();
	end
endmodule
bind pah_top pah_monitor #(.LED_ON_CYC(LED_ON_CYC)) u_mon (
	.clk_sys, .reset_n, .clk_en, .fault_pulse, .overheat_level, .alarm_clear_pin,
	.panic_stop_input, .alarm_led, .halt_motion, .motor_deenergise
);
`default_nettype wire
